// ---- logic/cgr_regs.svh ----
`ifndef CGR_REGS_SVH
`define CGR_REGS_SVH

// register indices; byte address is four times the index
`define CGR_IDX_VENDOR_HI      8'h00
`define CGR_IDX_VENDOR_LO      8'h01
`define CGR_IDX_PRODUCT        8'h02
`define CGR_IDX_DIE_REV        8'h03
`define CGR_IDX_SERIAL3        8'h04
`define CGR_IDX_SERIAL2        8'h05
`define CGR_IDX_SERIAL1        8'h06
`define CGR_IDX_SERIAL0        8'h07
`define CGR_IDX_TRIM7_HI       8'h64
`define CGR_IDX_TRIM7_LO       8'h65
`define CGR_IDX_TRIM8_HI       8'h66
`define CGR_IDX_TRIM8_LO       8'h67
`define CGR_IDX_TRIM_SW_HI     8'h68
`define CGR_IDX_TRIM_SW_LO     8'h69
`define CGR_IDX_SA_CTRL2       8'h75
`define CGR_IDX_SA_CTRL3       8'h76
`define CGR_IDX_SA_CAL_WAIT    8'h77
`define CGR_IDX_SA_CAL_BW      8'h78
`define CGR_IDX_SB_CTRL2       8'h83
`define CGR_IDX_SB_CTRL3       8'h84
`define CGR_IDX_SB_CAL_WAIT    8'h85
`define CGR_IDX_SB_CAL_BW      8'h86
`define CGR_IDX_NV_SCRC        8'h87
`define CGR_IDX_NV_CNT         8'h88
`define CGR_IDX_NV_CTL         8'h89
`define CGR_IDX_NV_LCRC        8'h8a
`define CGR_IDX_MEMPTR_HI      8'h8b
`define CGR_IDX_MEMPTR_LO      8'h8c
`define CGR_IDX_NV_DAT         8'h8d
`define CGR_IDX_SH_DAT         8'h8e
`define CGR_IDX_FX_DAT         8'h8f
`define CGR_IDX_NV_UNLK        8'h90
`define CGR_IDX_COMMIT_PG      8'h91
`define CGR_IDX_XCAP_HI        8'hc7
`define CGR_IDX_XCAP_LO        8'hc8

// reset values
`define CGR_RST_TRIM7_HI       8'h02
`define CGR_RST_TRIM7_LO       8'h47
`define CGR_RST_TRIM8_HI       8'h02
`define CGR_RST_TRIM8_LO       8'h9e
`define CGR_RST_CTRL3          8'h03
`define CGR_RST_CAL_WAIT       8'h01
`define CGR_RST_NV_CTL         8'h10
`define CGR_RST_ZERO           8'h00

// writable bit masks per register
`define CGR_MSK_10B_HI         8'h03
`define CGR_MSK_CTRL2          8'h80
`define CGR_MSK_CTRL3          8'h07
`define CGR_MSK_CAL_WAIT       8'h0f
`define CGR_MSK_CAL_BW         8'h01
`define CGR_MSK_NV_CTL         8'h7d
`define CGR_MSK_MEMPTR_HI      8'h0f
`define CGR_MSK_COMMIT_PG      8'h0f
`define CGR_MSK_FULL           8'hff

`endif

// ---- logic/cgr_pkg.sv ----
package cgr_pkg;
	typedef enum logic [2:0] {
		CGR_LD_IDLE = 3'b001,
		CGR_LD_LOAD = 3'b010,
		CGR_LD_DONE = 3'b100
	} cgr_load_t;

	typedef enum logic [1:0] {
		CGR_RESP_OKAY   = 2'b00,
		CGR_RESP_SLVERR = 2'b10
	} cgr_resp_t;
endpackage

// ---- logic/cgr_regbank.sv ----
// Summary of operation
// RULE_01 - vendor code is 16 bits: high byte at index 0, low byte at index 1
// RULE_02 - read-only 8-bit product code at index 2 names the device type
// RULE_03 - read-only 8-bit die revision at index 3 names the mask revision
// RULE_04 - 32-bit serial over indices 4 to 7, index 4 most significant byte
// RULE_05 - serial bytes are always loaded from the non-volatile image
// RULE_06 - serial is factory content; no register access may change it
// RULE_07 - writes to identification registers are ignored; reads keep stored values
`timescale 1ns/1ps
`include "cgr_regs.svh"

module cgr_regbank
	import cgr_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE  = 16'h5a5a, // arbitrary value
	parameter logic [7:0]  PRODUCT_CODE = 8'ha5,    // arbitrary value
	parameter logic [7:0]  DIE_REVISION = 8'h01,    // arbitrary value
	parameter int          ADDR_W       = 12
) (
	input  wire logic              I_CORE_CLK,
	input  wire logic              I_NRST,
	input  wire logic [ADDR_W-1:0] I_AWADDR,
	input  wire logic              I_AWVALID,
	output logic                   O_AWREADY,
	input  wire logic [31:0]       I_WDATA,
	input  wire logic [3:0]        I_WSTRB,
	input  wire logic              I_WVALID,
	output logic                   O_WREADY,
	output logic [1:0]             O_BRESP,
	output logic                   O_BVALID,
	input  wire logic              I_BREADY,
	input  wire logic [ADDR_W-1:0] I_ARADDR,
	input  wire logic              I_ARVALID,
	output logic                   O_ARREADY,
	output logic [31:0]            O_RDATA,
	output logic [1:0]             O_RRESP,
	output logic                   O_RVALID,
	input  wire logic              I_RREADY,
	input  wire logic [31:0]       I_NV_SERIAL,
	input  wire logic              I_NV_VALID,
	output logic                   O_SERIAL_LOADED,
	output logic [9:0]             O_TRIM_SW,
	output logic [9:0]             O_XCAP
);

	// the unmapped-address test needs at least one bit above the 10-bit map
	if (ADDR_W < 11) begin : g_addr_chk
		$error("ADDR_W too small for the register map");
	end

	logic             rst_s1_r;
	logic             rst_n;
	logic [7:0]       regs_r [0:255];
	logic [7:0]       wmask [0:255];
	logic [7:0]       rst_val [0:255];
	logic [31:0]      serial_r;
	cgr_load_t        ld_r;
	logic             aw_hold_r;
	logic             w_hold_r;
	logic [7:0]       aw_idx_r;
	logic             aw_ok_r;
	logic [7:0]       wdat_r;
	logic             wstb_r;
	logic             do_wr;
	logic [7:0]       ar_idx;
	logic             ar_ok;
	logic [7:0]       rd_byte;

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// per-index writable mask and reset value; zero mask means read-only or unmapped
	always_comb begin
		for (int i = 0; i < 256; i++) begin
			wmask[i]   = 8'h00;
			rst_val[i] = `CGR_RST_ZERO;
		end
		wmask[`CGR_IDX_TRIM7_HI]    = `CGR_MSK_10B_HI;
		rst_val[`CGR_IDX_TRIM7_HI]  = `CGR_RST_TRIM7_HI;
		wmask[`CGR_IDX_TRIM7_LO]    = `CGR_MSK_FULL;
		rst_val[`CGR_IDX_TRIM7_LO]  = `CGR_RST_TRIM7_LO;
		wmask[`CGR_IDX_TRIM8_HI]    = `CGR_MSK_10B_HI;
		rst_val[`CGR_IDX_TRIM8_HI]  = `CGR_RST_TRIM8_HI;
		wmask[`CGR_IDX_TRIM8_LO]    = `CGR_MSK_FULL;
		rst_val[`CGR_IDX_TRIM8_LO]  = `CGR_RST_TRIM8_LO;
		wmask[`CGR_IDX_TRIM_SW_HI]  = `CGR_MSK_10B_HI;
		wmask[`CGR_IDX_TRIM_SW_LO]  = `CGR_MSK_FULL;
		wmask[`CGR_IDX_SA_CTRL2]    = `CGR_MSK_CTRL2;
		wmask[`CGR_IDX_SA_CTRL3]    = `CGR_MSK_CTRL3;
		rst_val[`CGR_IDX_SA_CTRL3]  = `CGR_RST_CTRL3;
		wmask[`CGR_IDX_SA_CAL_WAIT] = `CGR_MSK_CAL_WAIT;
		rst_val[`CGR_IDX_SA_CAL_WAIT] = `CGR_RST_CAL_WAIT;
		wmask[`CGR_IDX_SA_CAL_BW]   = `CGR_MSK_CAL_BW;
		wmask[`CGR_IDX_SB_CTRL2]    = `CGR_MSK_CTRL2;
		wmask[`CGR_IDX_SB_CTRL3]    = `CGR_MSK_CTRL3;
		rst_val[`CGR_IDX_SB_CTRL3]  = `CGR_RST_CTRL3;
		wmask[`CGR_IDX_SB_CAL_WAIT] = `CGR_MSK_CAL_WAIT;
		rst_val[`CGR_IDX_SB_CAL_WAIT] = `CGR_RST_CAL_WAIT;
		wmask[`CGR_IDX_SB_CAL_BW]   = `CGR_MSK_CAL_BW;
		wmask[`CGR_IDX_NV_SCRC]     = `CGR_MSK_FULL;
		wmask[`CGR_IDX_NV_CNT]      = `CGR_MSK_FULL;
		wmask[`CGR_IDX_NV_CTL]      = `CGR_MSK_NV_CTL;
		rst_val[`CGR_IDX_NV_CTL]    = `CGR_RST_NV_CTL;
		wmask[`CGR_IDX_NV_LCRC]     = `CGR_MSK_FULL;
		wmask[`CGR_IDX_MEMPTR_HI]   = `CGR_MSK_MEMPTR_HI;
		wmask[`CGR_IDX_MEMPTR_LO]   = `CGR_MSK_FULL;
		wmask[`CGR_IDX_NV_DAT]      = `CGR_MSK_FULL;
		wmask[`CGR_IDX_SH_DAT]      = `CGR_MSK_FULL;
		wmask[`CGR_IDX_FX_DAT]      = `CGR_MSK_FULL;
		wmask[`CGR_IDX_NV_UNLK]     = `CGR_MSK_FULL;
		wmask[`CGR_IDX_COMMIT_PG]   = `CGR_MSK_COMMIT_PG;
		wmask[`CGR_IDX_XCAP_HI]     = `CGR_MSK_10B_HI;
		wmask[`CGR_IDX_XCAP_LO]     = `CGR_MSK_FULL;
	end

	// write address and data are taken independently, the write fires once both are held
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_r <= 1'b0;
			aw_idx_r  <= 8'h00;
			aw_ok_r   <= 1'b0;
		end else if (I_AWVALID && O_AWREADY) begin
			aw_hold_r <= 1'b1;
			aw_idx_r  <= I_AWADDR[9:2];
			aw_ok_r   <= (I_AWADDR[ADDR_W-1:10] == '0);
		end else if (do_wr) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			w_hold_r <= 1'b0;
			wdat_r   <= 8'h00;
			wstb_r   <= 1'b0;
		end else if (I_WVALID && O_WREADY) begin
			w_hold_r <= 1'b1;
			wdat_r   <= I_WDATA[7:0];
			wstb_r   <= I_WSTRB[0];
		end else if (do_wr) begin
			w_hold_r <= 1'b0;
		end
	end

	assign do_wr = aw_hold_r && w_hold_r && !O_BVALID;

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_AWREADY <= 1'b0;
			O_WREADY  <= 1'b0;
		end else begin
			O_AWREADY <= !aw_hold_r && !(I_AWVALID && O_AWREADY) && !O_BVALID;
			O_WREADY  <= !w_hold_r && !(I_WVALID && O_WREADY) && !O_BVALID;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_BVALID <= 1'b0;
			O_BRESP  <= CGR_RESP_OKAY;
		end else if (do_wr) begin
			O_BVALID <= 1'b1;
			O_BRESP  <= aw_ok_r ? CGR_RESP_OKAY : CGR_RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	// writable registers; identification indices have a zero mask so writes leave them alone
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 256; i++)
				regs_r[i] <= 8'h00;
		end else if (ld_r == CGR_LD_IDLE) begin
			for (int i = 0; i < 256; i++)
				regs_r[i] <= rst_val[i];
		end else if (do_wr && aw_ok_r && wstb_r) begin
			regs_r[aw_idx_r] <= wdat_r & wmask[aw_idx_r]; // RULE_07
		end
	end

	// serial identifier capture from the non-volatile image, once after reset
	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ld_r <= CGR_LD_IDLE;
		end else begin
			case (ld_r)
				CGR_LD_IDLE: ld_r <= CGR_LD_LOAD;
				CGR_LD_LOAD: if (I_NV_VALID) ld_r <= CGR_LD_DONE;
				CGR_LD_DONE: ld_r <= CGR_LD_DONE;
				default:     ld_r <= CGR_LD_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			serial_r <= 32'h0000_0000;
		end else if (ld_r == CGR_LD_LOAD && I_NV_VALID) begin
			serial_r <= I_NV_SERIAL; // RULE_05 RULE_06
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n)
			O_SERIAL_LOADED <= 1'b0;
		else
			O_SERIAL_LOADED <= (ld_r == CGR_LD_DONE);
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_TRIM_SW <= 10'h000;
			O_XCAP    <= 10'h000;
		end else begin
			O_TRIM_SW <= {regs_r[`CGR_IDX_TRIM_SW_HI][1:0], regs_r[`CGR_IDX_TRIM_SW_LO]};
			O_XCAP    <= {regs_r[`CGR_IDX_XCAP_HI][1:0], regs_r[`CGR_IDX_XCAP_LO]};
		end
	end

	assign ar_idx = I_ARADDR[9:2];
	assign ar_ok  = (I_ARADDR[ADDR_W-1:10] == '0);

	always_comb begin
		case (ar_idx)
			`CGR_IDX_VENDOR_HI: rd_byte = VENDOR_CODE[15:8]; // RULE_01
			`CGR_IDX_VENDOR_LO: rd_byte = VENDOR_CODE[7:0];  // RULE_01
			`CGR_IDX_PRODUCT:   rd_byte = PRODUCT_CODE;      // RULE_02
			`CGR_IDX_DIE_REV:   rd_byte = DIE_REVISION;      // RULE_03
			`CGR_IDX_SERIAL3:   rd_byte = serial_r[31:24];   // RULE_04
			`CGR_IDX_SERIAL2:   rd_byte = serial_r[23:16];   // RULE_04
			`CGR_IDX_SERIAL1:   rd_byte = serial_r[15:8];    // RULE_04
			`CGR_IDX_SERIAL0:   rd_byte = serial_r[7:0];     // RULE_04
			default:            rd_byte = regs_r[ar_idx];
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_ARREADY <= 1'b0;
		end else begin
			O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_RVALID <= 1'b0;
			O_RDATA  <= 32'h0000_0000;
			O_RRESP  <= CGR_RESP_OKAY;
		end else if (I_ARVALID && O_ARREADY) begin
			O_RVALID <= 1'b1;
			O_RDATA  <= ar_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
			O_RRESP  <= ar_ok ? CGR_RESP_OKAY : CGR_RESP_SLVERR;
		end else if (I_RREADY) begin
			O_RVALID <= 1'b0;
		end
	end

	sequence s_read_idx(logic [7:0] idx);
		I_ARVALID && O_ARREADY && ar_ok && ar_idx == idx;
	endsequence

	sequence s_write_fire;
		aw_hold_r && w_hold_r && !O_BVALID;
	endsequence

	sequence s_read_take;
		I_ARVALID && O_ARREADY;
	endsequence

	// identification bytes come from parameters and the captured serial
	a_vendor_hi_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_01
		s_read_idx(`CGR_IDX_VENDOR_HI) |=> O_RDATA[7:0] == VENDOR_CODE[15:8])
		else $error("vendor high byte wrong");
	a_vendor_lo_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_01
		s_read_idx(`CGR_IDX_VENDOR_LO) |=> O_RDATA == {24'h0, VENDOR_CODE[7:0]})
		else $error("vendor low byte wrong");
	a_product_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_02
		s_read_idx(`CGR_IDX_PRODUCT) |=> O_RVALID && O_RDATA[7:0] == PRODUCT_CODE)
		else $error("product code wrong");
	a_revision_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_03
		s_read_idx(`CGR_IDX_DIE_REV) |=> O_RDATA[7:0] == DIE_REVISION)
		else $error("die revision wrong");
	a_serial_msb_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_04
		s_read_idx(`CGR_IDX_SERIAL3) |=> O_RDATA[7:0] == serial_r[31:24])
		else $error("serial top byte wrong");
	a_serial_b2_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_04
		s_read_idx(`CGR_IDX_SERIAL2) |=> O_RDATA[7:0] == serial_r[23:16])
		else $error("serial byte two wrong");
	a_serial_b1_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_04
		s_read_idx(`CGR_IDX_SERIAL1) |=> O_RDATA[7:0] == serial_r[15:8])
		else $error("serial byte one wrong");
	a_serial_lsb_read: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_04
		s_read_idx(`CGR_IDX_SERIAL0) |=> O_RDATA[7:0] == serial_r[7:0])
		else $error("serial bottom byte wrong");

	// serial capture happens once, and only from a valid image
	a_serial_nv_load: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_05
		ld_r == CGR_LD_LOAD && I_NV_VALID |=> serial_r == $past(I_NV_SERIAL) ##1 O_SERIAL_LOADED)
		else $error("serial not taken from image");
	a_load_waits: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_05
		ld_r == CGR_LD_LOAD && !I_NV_VALID |=> ld_r == CGR_LD_LOAD && $stable(serial_r))
		else $error("serial taken without image");
	a_loaded_flag: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_05
		O_SERIAL_LOADED |-> ld_r == CGR_LD_DONE)
		else $error("loaded flag without capture");
	a_serial_stable: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_06
		ld_r == CGR_LD_DONE |=> $stable(serial_r))
		else $error("serial changed after load");
	a_id_write_ignored: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n) // RULE_07
		do_wr && aw_idx_r <= `CGR_IDX_SERIAL0 |=> $stable(serial_r) && O_BVALID)
		else $error("identification write had effect");

	// bus answers, holding and error responses
	a_write_answer: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		s_write_fire |=> O_BVALID && !O_AWREADY && !O_WREADY)
		else $error("write response missing");
	a_bresp_holds: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write response dropped early");
	a_write_slverr: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		s_write_fire ##0 !aw_ok_r |=> O_BRESP == CGR_RESP_SLVERR)
		else $error("unmapped write not refused");
	a_strobe_low_keeps: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		s_write_fire ##0 !wstb_r |=> $stable(regs_r[aw_idx_r]))
		else $error("write without strobe changed a register");
	a_read_answer: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		s_read_take |=> O_RVALID && !O_ARREADY)
		else $error("read response missing");
	a_rdata_holds: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
		else $error("read response dropped early");
	a_read_slverr: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		s_read_take ##0 !ar_ok |=> O_RRESP == CGR_RESP_SLVERR && O_RDATA == 32'h0)
		else $error("unmapped read not refused");
	a_read_ready_back: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		rst_n && !O_RVALID && !O_ARREADY |=> O_ARREADY)
		else $error("read ready not restored");

	// reset values and write masks of the configuration registers
	a_reset_values: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		$rose(ld_r == CGR_LD_LOAD) |-> regs_r[`CGR_IDX_TRIM7_LO] == `CGR_RST_TRIM7_LO &&
			regs_r[`CGR_IDX_NV_CTL] == `CGR_RST_NV_CTL)
		else $error("reset value not loaded");
	a_reserved_zero: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
		ld_r != CGR_LD_IDLE |-> regs_r[`CGR_IDX_XCAP_HI][7:2] == 6'h00 &&
			regs_r[`CGR_IDX_TRIM7_HI][7:2] == 6'h00)
		else $error("reserved bits became set");

endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "cgr_regs.svh"

module testbench;
	import cgr_pkg::*;

	logic        clk       = 1'b0;
	logic        rst_n     = 1'b0;
	logic [11:0] awaddr    = 12'h000;
	logic        awvalid   = 1'b0;
	logic        awready;
	logic [31:0] wdata     = 32'h0;
	logic [3:0]  wstrb     = 4'h0;
	logic        wvalid    = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready    = 1'b0;
	logic [11:0] araddr    = 12'h000;
	logic        arvalid   = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready    = 1'b0;
	logic [3:0]  wr_strb   = 4'hf;
	logic [31:0] nv_serial = 32'h13579bdf;
	logic        nv_valid  = 1'b0;
	logic        loaded;
	logic [9:0]  trim_sw;
	logic [9:0]  xcap;
	int          errors      = 0;
	int          checks_done = 0;
	int          cycles      = 0;
	logic [1:0]  r;
	logic [7:0]  id_exp [8] = '{8'hc3, 8'h5a, 8'ha5, 8'h01, 8'h13, 8'h57, 8'h9b, 8'hdf};
	// index, reset value, writable mask
	logic [23:0] tbl [27] = '{24'h640203, 24'h6547ff, 24'h660203, 24'h679eff, 24'h680003,
		24'h6900ff, 24'h750080, 24'h760307, 24'h77010f, 24'h780001, 24'h830080,
		24'h840307, 24'h85010f, 24'h860001, 24'h8700ff, 24'h8800ff, 24'h89107d,
		24'h8a00ff, 24'h8b000f, 24'h8c00ff, 24'h8d00ff, 24'h8e00ff, 24'h8f00ff,
		24'h9000ff, 24'h91000f, 24'hc70003, 24'hc800ff};

	always #20 clk = ~clk;

	// arbitrary vendor value; two distinct bytes expose a swapped byte order
	cgr_regbank #(.VENDOR_CODE(16'hc35a)) cgr_regbank_i (
		.I_CORE_CLK      (clk),
		.I_NRST          (rst_n),
		.I_AWADDR        (awaddr),
		.I_AWVALID       (awvalid),
		.O_AWREADY       (awready),
		.I_WDATA         (wdata),
		.I_WSTRB         (wstrb),
		.I_WVALID        (wvalid),
		.O_WREADY        (wready),
		.O_BRESP         (bresp),
		.O_BVALID        (bvalid),
		.I_BREADY        (bready),
		.I_ARADDR        (araddr),
		.I_ARVALID       (arvalid),
		.O_ARREADY       (arready),
		.O_RDATA         (rdata),
		.O_RRESP         (rresp),
		.O_RVALID        (rvalid),
		.I_RREADY        (rready),
		.I_NV_SERIAL     (nv_serial),
		.I_NV_VALID      (nv_valid),
		.O_SERIAL_LOADED (loaded),
		.O_TRIM_SW       (trim_sw),
		.O_XCAP          (xcap)
	);

	task automatic wrap_up();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// the run should end well inside this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= {24'h0, d};
		wstrb   <= wr_strb;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// read one register by index and compare data and response
	task automatic rdx(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0]  rs;
		rd({2'b00, idx, 2'b00}, d, rs);
		check(d, {24'h0, exp});
		check({30'h0, rs}, {30'h0, CGR_RESP_OKAY});
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdx(`CGR_IDX_SERIAL0, 8'h00);
		check({31'h0, loaded}, 32'h0);
		check({22'h0, trim_sw}, 32'h0);
		nv_valid <= 1'b1;
		while (loaded !== 1'b1) @(posedge clk);
		// a later image change must not reach the captured serial
		nv_serial <= 32'h2468ace0;
		for (int i = 0; i < 8; i++) begin
			rdx(i[7:0], id_exp[i]);
		end
		for (int i = 0; i < 8; i++) begin
			wr({2'b00, i[7:0], 2'b00}, ~id_exp[i], r);
			check({30'h0, r}, {30'h0, CGR_RESP_OKAY});
		end
		for (int i = 0; i < 8; i++) begin
			rdx(i[7:0], id_exp[i]);
		end
		for (int i = 0; i < 27; i++) begin
			rdx(tbl[i][23:16], tbl[i][15:8]);
			wr({2'b00, tbl[i][23:16], 2'b00}, 8'hff, r);
			rdx(tbl[i][23:16], tbl[i][7:0]);
		end
		check({22'h0, trim_sw}, 32'h3ff);
		check({22'h0, xcap}, 32'h3ff);
		// a write with no byte strobe must leave the register alone
		wr_strb = 4'h0;
		wr({2'b00, `CGR_IDX_TRIM_SW_LO, 2'b00}, 8'h12, r);
		wr_strb = 4'hf;
		check({30'h0, r}, {30'h0, CGR_RESP_OKAY});
		rdx(`CGR_IDX_TRIM_SW_LO, 8'hff);
		wr(12'h800, 8'h55, r);
		check({30'h0, r}, {30'h0, CGR_RESP_SLVERR});
		begin
			logic [31:0] d;
			rd(12'h800, d, r);
			check(d, 32'h0);
			check({30'h0, r}, {30'h0, CGR_RESP_SLVERR});
		end
		// second reset picks up the new image
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check({22'h0, xcap}, 32'h0);
		while (loaded !== 1'b1) @(posedge clk);
		rdx(`CGR_IDX_SERIAL3, 8'h24);
		rdx(`CGR_IDX_SERIAL0, 8'he0);
		wrap_up();
	end
endmodule
